// ===== design/rcr_alu.sv
// single-cycle arithmetic and shift unit with carry and overflow
`timescale 1ns/100ps
`default_nettype none
module rcr_alu
  import rcr_pkg::*;
(
  // operation and operands
  input wire rcr_op_t op,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic c_in,
  // results
  output logic [7:0] res,
  output logic [7:0] res_hi,
  output logic c_out,
  output logic v_out
);
  logic [8:0] sum9;
  logic [8:0] diff9;
  logic [15:0] prod;

  // every operation settles within the same cycle
  always_comb begin
    sum9 = {1'b0, a_in} + {1'b0, b_in};
    diff9 = {1'b0, a_in} - {1'b0, b_in};
    prod = {8'h00, a_in} * {8'h00, b_in};
    res = b_in;
    res_hi = 8'h00;
    c_out = c_in;
    v_out = 1'b0;
    case (op)
      OP_SHL, OP_SHLC: begin
        res = {b_in[6:0], (op == OP_SHLC) ? c_in : 1'b0};
        c_out = b_in[7];
        v_out = b_in[7] ^ b_in[6];
      end
      OP_SHR, OP_SHRC, OP_SHRA: begin
        res = {(op == OP_SHRC) ? c_in : ((op == OP_SHRA) ? b_in[7] : 1'b0), b_in[7:1]};
        c_out = b_in[0];
        v_out = res[7] ^ b_in[7]; // sign flip counts as signed overflow
      end
      OP_ADD: begin
        res = sum9[7:0];
        c_out = sum9[8];
        v_out = (a_in[7] == b_in[7]) && (res[7] != a_in[7]);
      end
      OP_SUB: begin
        res = diff9[7:0];
        c_out = ~diff9[8]; // zero on underflow
        v_out = (a_in[7] != b_in[7]) && (res[7] != a_in[7]);
      end
      OP_MUL: begin
        res = prod[7:0];
        res_hi = prod[15:8];
      end
      default: res = b_in;
    endcase
  end
endmodule
`default_nettype wire

// ===== design/rcr_core_regs.sv
// programmer-visible state of the risc core: registers, flags, pc, stack
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - sixteen internal registers, eight bits each
// - instruction words are 22 bits; 35 generic instructions, 8 addressing modes; rcr_op_t here codes 23 opcodes and no addressing modes
// - every instruction, jumps and 8x8 multiply included, completes in one cycle
// - register pairs join into 16-bit values such as the memory indices
// - after halt, an interrupt or an event request wakes the core
// - interrupt wake branches to the service vector; event wake resumes after halt; here a wake by a disabled interrupt also resumes
// - pc is 16 bits and holds the next instruction address
// - hardware stack keeps return addresses for calls and interrupt entry
// - register roles: three general, offset, four indices, program index, status, acc
// - status bit 7 enables level 2, bit 6 level 1, bit 5 global enable
// - status bits 4,3,2 hold pending interrupt levels 2,1,0
// - status bits 1,0 hold pending events; software clears them once served
// - zero flag set exactly when the accumulator holds zero
// - shifts put the bit shifted out into carry
// - unsigned add sets carry on overflow; subtract clears it on underflow
// - return from interrupt restores pc from stack, pops, sets global enable
module rcr_core_regs
  import rcr_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction stream from fetch
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  // requests from interrupt and event handlers
  input wire logic [2:0] irq_req,
  input wire logic [1:0] event_req,
  // software register port
  input wire logic [4:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  // core state towards memories
  output logic [PC_W-1:0] pc_out,
  output logic [15:0] data_index_zero,
  output logic [15:0] program_memory_pointer,
  output logic [7:0] data_offset_reg,
  output logic [7:0] acc_out,
  output logic [2:0] flags_out,
  output logic halted,
  output logic irq_out
);
  // register storage
  logic [7:0] file_reg [IDX_STAT];
  logic [7:0] stat_reg;
  logic [7:0] acc_reg;
  logic [PC_W-1:0] pc_reg;
  logic z_reg;
  logic c_reg;
  logic v_reg;
  logic halted_reg;
  logic ready_reg;
  logic [BI_W-1:0] bi_status_reg;
  logic [BI_W-1:0] bi_mask_reg;
  logic [7:0] sw_rdata_reg;
  logic irq_out_reg;

  // decoded fields
  rcr_op_t op;
  logic [3:0] dst;
  logic [3:0] src;
  logic [7:0] imm;
  logic [15:0] jaddr;
  logic [7:0] dst_val;
  logic [7:0] src_val;
  logic [15:0] ip_val;

  // execution control
  logic exec;
  logic irq_ok0;
  logic irq_ok1;
  logic irq_ok2;
  logic take_irq;
  logic [15:0] irq_vec;
  logic any_wake;
  logic ins_wr;
  logic [7:0] ins_wdata;
  logic acc_ld;
  logic [7:0] acc_next;
  logic [7:0] stat_next;
  logic cv_ld;
  logic [PC_W-1:0] pc_next;
  logic st_push;
  logic st_pop;
  logic [15:0] st_push_data;
  logic [15:0] st_top;
  logic ip_ld;
  logic [BI_W-1:0] bi_events;

  // alu results
  logic [7:0] alu_res;
  logic [7:0] alu_hi;
  logic alu_c;
  logic alu_v;

  // read any of the sixteen internal registers by index
  function automatic logic [7:0] reg_rd(input logic [3:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == IDX_STAT) begin
      v = stat_reg;
    end else if (idx == IDX_ACC) begin
      v = acc_reg;
    end else begin
      v = file_reg[idx];
    end
    return v;
  endfunction

  // instruction fields of the 22-bit word
  assign op = rcr_op_t'(instr_word[OP_MSB:OP_LSB]);
  assign dst = instr_word[DST_MSB:DST_LSB];
  assign src = instr_word[SRC_MSB:SRC_LSB];
  assign imm = instr_word[7:0];
  assign jaddr = instr_word[15:0];
  assign dst_val = reg_rd(dst);
  assign src_val = reg_rd(src);
  assign ip_val = {file_reg[IDX_IPH], file_reg[IDX_IPL]};

  // level eligibility; level 0 has no own enable and wins over the others
  assign irq_ok0 = stat_reg[ST_GLOBAL_IRQ_ENABLE] & stat_reg[ST_LEVEL0_IRQ_PENDING];
  assign irq_ok1 = stat_reg[ST_GLOBAL_IRQ_ENABLE] & stat_reg[ST_LEVEL1_IRQ_PENDING]
                   & stat_reg[ST_LEVEL1_IRQ_ENABLE];
  assign irq_ok2 = stat_reg[ST_GLOBAL_IRQ_ENABLE] & stat_reg[ST_LEVEL2_IRQ_PENDING]
                   & stat_reg[ST_LEVEL2_IRQ_ENABLE];
  assign take_irq = irq_ok0 | irq_ok1 | irq_ok2;
  assign irq_vec = irq_ok0 ? VEC_LEVEL0 : (irq_ok1 ? VEC_LEVEL1 : VEC_LEVEL2);
  // any pending request or event ends a halt, enabled or not
  assign any_wake = |stat_reg[ST_LEVEL2_IRQ_PENDING:ST_LEVEL0_EVENT_PENDING];
  // an offered instruction is dropped in a cycle that enters a service routine
  assign exec = instr_valid & ~halted_reg & ~take_irq;

  rcr_alu u_alu (
    .op(op),
    .a_in(dst_val),
    .b_in((op == OP_ADD || op == OP_SUB || op == OP_MUL) ? src_val : src_val),
    .c_in(c_reg),
    .res(alu_res),
    .res_hi(alu_hi),
    .c_out(alu_c),
    .v_out(alu_v)
  );

  rcr_ret_stack #(.DEPTH(DEPTH), .W(16)) u_stack (
    .clk(clk),
    .nrst(nrst),
    .push(st_push),
    .pop(st_pop),
    .push_data(st_push_data),
    .top(st_top)
  );

  // execute: register write, accumulator load, flags and stack traffic
  always_comb begin
    ins_wr = 1'b0;
    ins_wdata = 8'h00;
    acc_ld = 1'b0;
    acc_next = acc_reg;
    cv_ld = 1'b0;
    st_push = 1'b0;
    st_pop = 1'b0;
    st_push_data = pc_reg + 16'h0001;
    ip_ld = 1'b0;
    if (take_irq && (!halted_reg || any_wake)) begin
      st_push = 1'b1; // return to the dropped or woken instruction
      st_push_data = pc_reg;
    end else if (exec) begin
      case (op)
        OP_CALL: st_push = 1'b1;
        OP_RET, OP_RETI: st_pop = 1'b1;
        OP_PUSH: begin
          st_push = 1'b1;
          st_push_data = ip_val;
        end
        OP_POP: begin
          st_pop = 1'b1;
          ip_ld = 1'b1;
        end
        OP_MOVI: begin
          ins_wr = 1'b1;
          ins_wdata = imm;
          acc_ld = 1'b1;
          acc_next = imm;
        end
        OP_MOVR: begin
          ins_wr = 1'b1;
          ins_wdata = src_val;
          acc_ld = 1'b1;
          acc_next = src_val;
        end
        OP_SHL, OP_SHLC, OP_SHR, OP_SHRC, OP_SHRA, OP_ADD, OP_SUB: begin
          ins_wr = 1'b1;
          ins_wdata = alu_res;
          acc_ld = 1'b1;
          acc_next = alu_res;
          cv_ld = 1'b1;
        end
        OP_MUL: begin
          // low byte to the accumulator, high byte to the destination
          ins_wr = 1'b1;
          ins_wdata = alu_hi;
          acc_ld = 1'b1;
          acc_next = alu_res;
        end
        default: ins_wr = 1'b0;
      endcase
      if (ins_wr && dst == IDX_ACC) begin
        acc_next = ins_wdata;
      end
    end
    // software may load the accumulator when the core does not
    if (!acc_ld && sw_wr && sw_addr == {1'b0, IDX_ACC}) begin
      acc_ld = 1'b1;
      acc_next = sw_wdata;
    end
  end

  // program counter sequencing
  always_comb begin
    pc_next = pc_reg;
    if (halted_reg) begin
      // an event wake simply resumes at the instruction after the halt
      pc_next = (take_irq && any_wake) ? irq_vec : pc_reg;
    end else if (take_irq) begin
      pc_next = irq_vec;
    end else if (exec) begin
      pc_next = pc_reg + 16'h0001;
      case (op)
        OP_JUMP, OP_CALL: pc_next = jaddr;
        OP_JUMP_IP: pc_next = ip_val;
        OP_JZ: pc_next = z_reg ? jaddr : pc_reg + 16'h0001;
        OP_JNZ: pc_next = !z_reg ? jaddr : pc_reg + 16'h0001;
        OP_JC: pc_next = c_reg ? jaddr : pc_reg + 16'h0001;
        OP_JNC: pc_next = !c_reg ? jaddr : pc_reg + 16'h0001;
        OP_RET, OP_RETI: pc_next = st_top;
        default: pc_next = pc_reg + 16'h0001;
      endcase
    end
  end

  // status register: writes first, then enable changes, pending sets last
  always_comb begin
    stat_next = stat_reg;
    if (sw_wr && sw_addr == {1'b0, IDX_STAT}) begin
      stat_next = sw_wdata; // software clears served bits
    end
    if (ins_wr && dst == IDX_STAT) begin
      stat_next = ins_wdata;
    end
    if (take_irq && (!halted_reg || any_wake)) begin
      stat_next[ST_GLOBAL_IRQ_ENABLE] = 1'b0;
    end else if (exec && op == OP_RETI) begin
      stat_next[ST_GLOBAL_IRQ_ENABLE] = 1'b1;
    end
    // a request arriving with a clear is kept
    stat_next[ST_LEVEL2_IRQ_PENDING] = stat_next[ST_LEVEL2_IRQ_PENDING] | irq_req[2];
    stat_next[ST_LEVEL1_IRQ_PENDING] = stat_next[ST_LEVEL1_IRQ_PENDING] | irq_req[1];
    stat_next[ST_LEVEL0_IRQ_PENDING] = stat_next[ST_LEVEL0_IRQ_PENDING] | irq_req[0];
    stat_next[ST_LEVEL1_EVENT_PENDING] = stat_next[ST_LEVEL1_EVENT_PENDING]
                                         | event_req[1];
    stat_next[ST_LEVEL0_EVENT_PENDING] = stat_next[ST_LEVEL0_EVENT_PENDING]
                                         | event_req[0];
  end

  // general, offset and index registers: core write beats software write
  for (genvar r = 0; r < IDX_STAT; r++) begin : g_file
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        file_reg[r] <= 8'h00;
      end else if (ins_wr && dst == r) begin
        file_reg[r] <= ins_wdata;
      end else if (ip_ld && (r == IDX_IPH || r == IDX_IPL)) begin
        file_reg[r] <= (r == IDX_IPH) ? st_top[15:8] : st_top[7:0];
      end else if (sw_wr && sw_addr == 5'(r)) begin
        file_reg[r] <= sw_wdata;
      end
    end
  end

  // status register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // accumulator and zero flag move together
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= 8'h00;
      z_reg <= 1'b1;
    end else if (acc_ld) begin
      acc_reg <= acc_next;
      z_reg <= (acc_next == 8'h00);
    end
  end

  // carry and overflow change only on shifts and add or subtract
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c_reg <= 1'b0;
      v_reg <= 1'b0;
    end else if (cv_ld) begin
      c_reg <= alu_c;
      v_reg <= alu_v;
    end
  end

  // program counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_reg <= PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // halt state: entered by the halt op, left on any pending request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      halted_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else if (halted_reg) begin
      halted_reg <= ~any_wake;
      ready_reg <= any_wake;
    end else if (exec && op == OP_HALT) begin
      halted_reg <= 1'b1;
      ready_reg <= 1'b0;
    end
  end

  // block events: service entry, wake without service entry (event or disabled request), halt entry
  always_comb begin
    bi_events = '0;
    bi_events[BI_IRQ_ENTERED] = take_irq && (!halted_reg || any_wake);
    bi_events[BI_EVENT_WAKE] = halted_reg && any_wake && !take_irq;
    bi_events[BI_HALT_ENTERED] = exec && op == OP_HALT;
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bi_status_reg <= '0;
    end else if (sw_wr && sw_addr == SW_ADDR_IRQ_STATUS) begin
      bi_status_reg <= (bi_status_reg & ~sw_wdata[BI_W-1:0]) | bi_events;
    end else begin
      bi_status_reg <= bi_status_reg | bi_events;
    end
  end

  // interrupt mask
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bi_mask_reg <= '0;
    end else if (sw_wr && sw_addr == SW_ADDR_IRQ_MASK) begin
      bi_mask_reg <= sw_wdata[BI_W-1:0];
    end
  end

  // interrupt line is registered, so it trails the status bit by one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_out_reg <= 1'b0;
    end else begin
      irq_out_reg <= |(bi_status_reg & bi_mask_reg);
    end
  end

  // software read data, valid the cycle after the strobe only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_rdata_reg <= 8'h00;
    end else if (sw_rd) begin
      if (!sw_addr[4]) begin
        sw_rdata_reg <= reg_rd(sw_addr[3:0]);
      end else if (sw_addr == SW_ADDR_IRQ_STATUS) begin
        sw_rdata_reg <= {5'h00, bi_status_reg};
      end else if (sw_addr == SW_ADDR_IRQ_MASK) begin
        sw_rdata_reg <= {5'h00, bi_mask_reg};
      end else if (sw_addr == SW_ADDR_CORE_STATE) begin
        sw_rdata_reg <= {4'h0, halted_reg, v_reg, c_reg, z_reg};
      end else begin
        sw_rdata_reg <= 8'h00;
      end
    end else begin
      sw_rdata_reg <= 8'h00;
    end
  end

  // outputs straight from flip-flops
  assign sw_rdata = sw_rdata_reg;
  assign pc_out = pc_reg;
  assign data_index_zero = {file_reg[IDX_I0H], file_reg[IDX_I0L]};
  assign program_memory_pointer = ip_val;
  assign data_offset_reg = file_reg[IDX_DATA_OFFSET];
  assign acc_out = acc_reg;
  assign flags_out = {v_reg, c_reg, z_reg};
  assign halted = halted_reg;
  assign instr_ready = ready_reg;
  assign irq_out = irq_out_reg;
endmodule
`default_nettype wire

// ===== design/rcr_ret_stack.sv
// return-address stack of shifting flip-flop entries
`timescale 1ns/100ps
`default_nettype none
module rcr_ret_stack #(
  parameter int DEPTH = 8,
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // push and pop
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] push_data,
  // top entry
  output logic [W-1:0] top
);
  logic [W-1:0] st [DEPTH];

  // each entry takes its upper or lower neighbour; bottom entry is lost on overflow
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        st[i] <= '0;
      end else if (push) begin
        st[i] <= (i == 0) ? push_data : st[(i == 0) ? 0 : i-1];
      end else if (pop) begin
        st[i] <= (i == DEPTH-1) ? '0 : st[(i == DEPTH-1) ? i : i+1];
      end
    end
  end

  assign top = st[0];
endmodule
`default_nettype wire

// ===== shared/rcr_pkg.sv
// shared constants and types of the risc core register file
package rcr_pkg;
  // instruction word layout
  localparam int INSTR_W = 22;
  localparam int OP_MSB = 21;
  localparam int OP_LSB = 16;
  localparam int DST_MSB = 15;
  localparam int DST_LSB = 12;
  localparam int SRC_MSB = 11;
  localparam int SRC_LSB = 8;
  localparam int NUM_GENERIC_INSTR = 35;
  localparam int NUM_ADDR_MODES = 8;
  // register file geometry
  localparam int NUM_REGS = 16;
  localparam int REG_W = 8;
  localparam int PC_W = 16;
  localparam int STACK_DEPTH = 8;
  // internal register indices
  localparam logic [3:0] IDX_DATA_OFFSET = 4'h3;
  localparam logic [3:0] IDX_I0H = 4'h4;
  localparam logic [3:0] IDX_I0L = 4'h5;
  localparam logic [3:0] IDX_IPH = 4'hc;
  localparam logic [3:0] IDX_IPL = 4'hd;
  localparam logic [3:0] IDX_STAT = 4'he;
  localparam logic [3:0] IDX_ACC = 4'hf;
  // status register fields
  localparam int ST_LEVEL2_IRQ_ENABLE = 7;
  localparam int ST_LEVEL1_IRQ_ENABLE = 6;
  localparam int ST_GLOBAL_IRQ_ENABLE = 5;
  localparam int ST_LEVEL2_IRQ_PENDING = 4;
  localparam int ST_LEVEL1_IRQ_PENDING = 3;
  localparam int ST_LEVEL0_IRQ_PENDING = 2;
  localparam int ST_LEVEL1_EVENT_PENDING = 1;
  localparam int ST_LEVEL0_EVENT_PENDING = 0;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // software port map: 0x00..0x0f internal registers, then block registers
  localparam logic [4:0] SW_ADDR_IRQ_STATUS = 5'h10;
  localparam logic [4:0] SW_ADDR_IRQ_MASK = 5'h11;
  localparam logic [4:0] SW_ADDR_CORE_STATE = 5'h12;
  // block interrupt status bits
  localparam int BI_IRQ_ENTERED = 0;
  localparam int BI_EVENT_WAKE = 1;
  localparam int BI_HALT_ENTERED = 2;
  localparam int BI_W = 3;
  // interrupt vectors per level
  localparam logic [15:0] VEC_LEVEL0 = 16'h0004;
  localparam logic [15:0] VEC_LEVEL1 = 16'h0008;
  localparam logic [15:0] VEC_LEVEL2 = 16'h000c;
  localparam logic [15:0] PC_RESET = 16'h0000;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_JUMP = 6'h01, OP_JUMP_IP = 6'h02, OP_JZ = 6'h03,
    OP_JNZ = 6'h04, OP_JC = 6'h05, OP_JNC = 6'h06, OP_CALL = 6'h07,
    OP_RET = 6'h08, OP_RETI = 6'h09, OP_PUSH = 6'h0a, OP_POP = 6'h0b,
    OP_MOVI = 6'h0c, OP_MOVR = 6'h0d, OP_SHL = 6'h0e, OP_SHLC = 6'h0f,
    OP_SHR = 6'h10, OP_SHRC = 6'h11, OP_SHRA = 6'h12, OP_ADD = 6'h13,
    OP_SUB = 6'h14, OP_MUL = 6'h15, OP_HALT = 6'h16
  } rcr_op_t;
endpackage

// ===== verif/rcr_core_regs_asserts.sv
// assertion checker for the risc core register file
`timescale 1ns/100ps
`default_nettype none
module rcr_core_regs_chk
  import rcr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction stream
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic instr_valid,
  input wire logic instr_ready,
  // software port
  input wire logic sw_rd,
  input wire logic [7:0] sw_rdata,
  // core state
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [7:0] acc_out,
  input wire logic [2:0] flags_out,
  input wire logic halted
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // an interrupt taken in the same cycle drops the instruction, so a vector is allowed
  function automatic logic is_vec(logic [15:0] p);
    return p == VEC_LEVEL0 || p == VEC_LEVEL1 || p == VEC_LEVEL2;
  endfunction
  sequence s_take(logic [5:0] o);
    instr_valid && instr_ready && instr_word[OP_MSB:OP_LSB] == o;
  endsequence
  // call immediately followed by a return at the call target
  sequence s_call_ret;
    s_take(OP_CALL) ##1 (instr_valid && instr_ready && instr_word[OP_MSB:OP_LSB] == OP_RET
      && pc_out == $past(instr_word[15:0]));
  endsequence
  a_zero_flag: assert property (
    flags_out[0] == (acc_out == 8'h00)) else $error("zero flag disagrees with accumulator");
  a_ready_halt: assert property (
    instr_ready == !halted) else $error("ready does not follow halt state");
  a_rdata_idle: assert property (
    !$past(sw_rd) |-> sw_rdata == 8'h00) else $error("read data outside read slot");
  a_halt_entry: assert property (
    $rose(halted) |-> pc_out == $past(pc_out) + 16'h0001) else $error("halt left bad pc");
  a_wake_target: assert property (
    $fell(halted) |-> (pc_out == $past(pc_out) || is_vec(pc_out)))
    else $error("wake went to wrong address");
  a_movi_load: assert property (
    s_take(OP_MOVI) |=> (acc_out == $past(instr_word[7:0]) || is_vec(pc_out)))
    else $error("immediate load not done in one cycle");
  a_mul_single: assert property (
    s_take(OP_MUL) |=> (pc_out == $past(pc_out) + 16'h0001 || is_vec(pc_out)))
    else $error("multiply did not advance pc in one cycle");
  a_call_return: assert property (
    s_call_ret |=> (pc_out == $past(pc_out, 2) + 16'h0001 || is_vec(pc_out)))
    else $error("return did not reach the address after the call");
endmodule
bind rcr_core_regs rcr_core_regs_chk chk (.clk(clk), .nrst(nrst), .instr_word(instr_word),
  .instr_valid(instr_valid), .instr_ready(instr_ready), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
  .pc_out(pc_out), .acc_out(acc_out), .flags_out(flags_out), .halted(halted));
`default_nettype wire

// ===== verif/rcr_core_regs_tb.sv
// self-checking testbench of the risc core register file
`timescale 1ns/100ps
`default_nettype none
module rcr_core_regs_tb;
  import rcr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] sw_addr = 5'h00;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic slow = 1'b0;
  logic [INSTR_W-1:0] instr_word;
  logic instr_valid, instr_ready, halted, irq_out;
  logic [2:0] irq_req, flags_out;
  logic [1:0] event_req;
  logic [7:0] sw_rdata, acc_out, data_offset_reg;
  logic [15:0] pc_out, data_index_zero, program_memory_pointer;
  int errors = 0;
  int checks = 0;
  always #20 clk = ~clk;
  rcr_core_regs dut (.clk(clk), .nrst(nrst), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .irq_req(irq_req),
    .event_req(event_req), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pc_out(pc_out), .data_index_zero(data_index_zero),
    .program_memory_pointer(program_memory_pointer), .data_offset_reg(data_offset_reg),
    .acc_out(acc_out), .flags_out(flags_out), .halted(halted), .irq_out(irq_out));
  rcr_far_end far (.clk(clk), .pc_out(pc_out), .slow(slow), .instr_word(instr_word),
    .instr_valid(instr_valid), .irq_req(irq_req), .event_req(event_req));
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    chk({8'h00, sw_rdata}, {8'h00, exp});
  endtask
  // leave the current halt if any, then wait for the next one
  task automatic wait_halt(input logic [15:0] pc);
    int n;
    n = 0;
    while (halted !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (halted !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({15'h0000, halted}, 16'h0001);
    chk(pc_out, pc);
  endtask
  // one program word: opcode, dst and src nibbles, immediate
  task automatic p(input logic [6:0] a, input rcr_op_t o, input logic [7:0] ds,
                   input logic [7:0] i);
    far.mem[a] = {o, ds, i};
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    stop_test();
  end
  initial begin
    @(posedge clk);
    p(7'h00, OP_JUMP, 8'h00, 8'h20);
    p(7'h08, OP_MOVI, 8'he0, 8'h40);
    p(7'h09, OP_MOVI, 8'ha0, 8'h55);
    p(7'h0a, OP_RETI, 8'h00, 8'h00);
    p(7'h20, OP_MOVI, 8'h00, 8'h80);
    p(7'h21, OP_SHR, 8'h20, 8'h00);
    p(7'h22, OP_HALT, 8'h00, 8'h00);
    p(7'h23, OP_MOVI, 8'he0, 8'h00);
    p(7'h24, OP_SHL, 8'h10, 8'h00);
    p(7'h25, OP_HALT, 8'h00, 8'h00);
    p(7'h26, OP_MOVI, 8'he0, 8'h00);
    p(7'h27, OP_MOVI, 8'h40, 8'h12);
    p(7'h28, OP_MOVI, 8'h50, 8'h34);
    p(7'h29, OP_MOVI, 8'h60, 8'h7f);
    p(7'h2a, OP_MOVI, 8'h70, 8'h01);
    p(7'h2b, OP_ADD, 8'h67, 8'h00);
    p(7'h2c, OP_HALT, 8'h00, 8'h00);
    p(7'h2d, OP_MOVI, 8'he0, 8'h00);
    p(7'h2e, OP_MOVI, 8'h80, 8'hff);
    p(7'h2f, OP_ADD, 8'h87, 8'h00);
    p(7'h30, OP_HALT, 8'h00, 8'h00);
    p(7'h31, OP_MOVI, 8'he0, 8'h00);
    p(7'h32, OP_SUB, 8'h87, 8'h00);
    p(7'h33, OP_MUL, 8'h88, 8'h00);
    p(7'h34, OP_CALL, 8'h00, 8'h40);
    p(7'h40, OP_RET, 8'h00, 8'h00);
    p(7'h35, OP_HALT, 8'h00, 8'h00);
    p(7'h36, OP_HALT, 8'h00, 8'h00);
    p(7'h37, OP_MOVI, 8'he0, 8'h00);
    p(7'h38, OP_SHRA, 8'h88, 8'h00);
    p(7'h39, OP_SHRC, 8'h88, 8'h00);
    p(7'h3a, OP_JC, 8'h00, 8'h3c);
    p(7'h3b, OP_HALT, 8'h00, 8'h00);
    p(7'h3c, OP_MOVR, 8'h9a, 8'h00);
    p(7'h3d, OP_HALT, 8'h00, 8'h00);
    repeat (10) @(posedge clk);
    #1;
    chk(pc_out, 16'h0000);
    chk({13'h0000, flags_out}, 16'h0001);
    chk({14'h0000, halted, irq_out}, 16'h0000);
    @(posedge clk);
    nrst <= 1'b1;
    rd(5'h0e, 8'h00);
    wait_halt(16'h0023);
    rd(5'h02, 8'h40);
    chk({13'h0000, flags_out & 3'b010}, 16'h0000);
    far.pulse(3'h0, 2'h1);
    wait_halt(16'h0026);
    chk({13'h0000, flags_out & 3'b011}, 16'h0003);
    slow <= 1'b1;
    far.pulse(3'h0, 2'h2);
    wait_halt(16'h002d);
    slow <= 1'b0;
    chk({13'h0000, flags_out}, 16'h0004);
    chk(data_index_zero, 16'h1234);
    rd(5'h06, 8'h80);
    far.pulse(3'h0, 2'h1);
    wait_halt(16'h0031);
    chk({13'h0000, flags_out}, 16'h0003);
    far.pulse(3'h0, 2'h2);
    wait_halt(16'h0036);
    chk({13'h0000, flags_out}, 16'h0000);
    chk({8'h00, acc_out}, 16'h0001);
    rd(5'h08, 8'hfe);
    wr(5'h0e, 8'h60);
    far.pulse(3'h2, 2'h0);
    wait_halt(16'h0037);
    rd(5'h0a, 8'h55);
    rd(5'h0e, 8'h60);
    rd(5'h12, 8'h08);
    rd(5'h10, 8'h07);
    chk({15'h0000, irq_out}, 16'h0000);
    wr(5'h11, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq_out}, 16'h0001);
    wr(5'h10, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq_out}, 16'h0000);
    rd(5'h10, 8'h05);
    wr(5'h13, 8'hff);
    rd(5'h13, 8'h00);
    wr(5'h03, 8'h5a);
    wr(5'h0c, 8'h01);
    wr(5'h0d, 8'h23);
    #1;
    chk({8'h00, data_offset_reg}, 16'h005a);
    chk(program_memory_pointer, 16'h0123);
    far.pulse(3'h0, 2'h1);
    wait_halt(16'h003e);
    chk({13'h0000, flags_out}, 16'h0006);
    rd(5'h08, 8'h7f);
    rd(5'h09, 8'h55);
    chk({15'h0000, irq_out}, 16'h0001);
    stop_test();
  end
endmodule
`default_nettype wire

// ===== verif/rcr_far_end.sv
// program memory plus interrupt and event sources facing the core
`timescale 1ns/100ps
`default_nettype none
module rcr_far_end
  import rcr_pkg::*;
(
  // clock
  input wire logic clk,
  // core side
  input wire logic [PC_W-1:0] pc_out,
  input wire logic slow,
  output logic [INSTR_W-1:0] instr_word,
  output logic instr_valid,
  // handler requests
  output logic [2:0] irq_req,
  output logic [1:0] event_req
);
  logic [INSTR_W-1:0] mem [0:127];
  logic tick;
  initial begin
    tick = 1'b0;
    irq_req = 3'h0;
    event_req = 2'h0;
    for (int i = 0; i < 128; i++) begin
      mem[i] = '0;
    end
  end
  // slow mode offers an instruction only every other cycle
  always @(posedge clk) begin
    tick <= ~tick;
  end
  assign instr_valid = !slow || tick;
  // no stale word while nothing is offered
  assign instr_word = instr_valid ? mem[pc_out[6:0]] : ~mem[pc_out[6:0]];
  // one-cycle request pulse; bit 2 low, 1 mid, 0 high group
  task automatic pulse(input logic [2:0] irq, input logic [1:0] ev);
    @(posedge clk);
    irq_req <= irq;
    event_req <= ev;
    @(posedge clk);
    irq_req <= 3'h0;
    event_req <= 2'h0;
  endtask
endmodule
`default_nettype wire
